// ---- rtl/arf_regs.svh ----
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH

// ****************************************************************
// Register byte addresses on the bus
// ****************************************************************
`define ARF_OFF_CTRL_A       12'h000
`define ARF_OFF_CTRL_B       12'h004
`define ARF_OFF_CTRL_C       12'h008
`define ARF_OFF_RES_HIGH     12'h00C
`define ARF_OFF_RES_LOW      12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define ARF_A_ON_BIT         0
`define ARF_A_GO_BIT         1
`define ARF_A_CHAN_LSB       2
`define ARF_B_VREF_LSB       4
`define ARF_C_CLK_LSB        0
`define ARF_C_ACQ_LSB        3
`define ARF_C_FMT_BIT        7

// ****************************************************************
// Reset values of the control registers
// ****************************************************************
`define ARF_RST_CTRL         8'h00
`define ARF_RST_CHAN         4'h0
`define ARF_RST_VREF         2'h0
`define ARF_RST_ACQ          3'h0
`define ARF_RST_CLK          3'h0
`define ARF_RST_ON           1'b0
`define ARF_RST_GO           1'b0
`define ARF_RST_FMT          1'b0

// ****************************************************************
// Acquisition lengths in converter clock periods, per code
// ****************************************************************
`define ARF_ACQ_0            5'h00
`define ARF_ACQ_1            5'h02
`define ARF_ACQ_2            5'h04
`define ARF_ACQ_3            5'h06
`define ARF_ACQ_4            5'h08
`define ARF_ACQ_5            5'h0C
`define ARF_ACQ_6            5'h10
`define ARF_ACQ_7            5'h14

// ****************************************************************
// Converter clock divider terminal counts (divisor minus one)
// ****************************************************************
`define ARF_DIV_2            6'h01
`define ARF_DIV_4            6'h03
`define ARF_DIV_8            6'h07
`define ARF_DIV_16           6'h0F
`define ARF_DIV_32           6'h1F
`define ARF_DIV_64           6'h3F
`define ARF_DIV_RC           6'h0F

// SAR start values
`define ARF_SAR_MSB          10'h200
`define ARF_SAR_ZERO         10'h000

`endif

// ---- rtl/arf_pkg.sv ----
package arf_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ARF_IDLE  = 4'b0001,
    ARF_ACQ   = 4'b0010,
    ARF_CONV  = 4'b0100,
    ARF_DISCH = 4'b1000
  } arf_state_t;

  typedef logic [7:0]  arf_byte_t;
  typedef logic [9:0]  arf_code_t;
  typedef logic [2:0]  arf_sel_t;

endpackage

// ---- rtl/arf_seq_if.sv ----
`timescale 1ns/100ps
// Link between the register file and the conversion sequencer
interface arf_seq_if;
  import arf_pkg::*;
  logic      run;        // Conversion requested and converter on
  arf_sel_t  acq_code;   // Acquisition length code
  arf_sel_t  clk_sel;    // Converter clock select
  logic      comp_in;    // Comparator answer for the current trial
  logic      busy;       // Sequencer not idle
  logic      done;       // One-cycle pulse, result valid
  arf_code_t result;     // Finished 10-bit result
  arf_code_t trial;      // Trial code to the DAC
  logic      hold_on;    // Hold capacitor connected to channel
  logic      discharge;  // Hold capacitor being emptied

  modport regs (output run, acq_code, clk_sel, comp_in,
                input  busy, done, result, trial, hold_on, discharge);
  modport seq  (input  run, acq_code, clk_sel, comp_in,
                output busy, done, result, trial, hold_on, discharge);
endinterface

// ---- rtl/arf_seq.sv ----
`timescale 1ns/100ps
`include "arf_regs.svh"
// Acquisition, successive approximation and discharge sequencer
module arf_seq (
  input wire logic clk,
  input wire logic arst_n,
  arf_seq_if.seq   sq
);
  import arf_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [4:0] acq_len(input arf_sel_t code);
    case (code)
      3'h0:    acq_len = `ARF_ACQ_0;
      3'h1:    acq_len = `ARF_ACQ_1;
      3'h2:    acq_len = `ARF_ACQ_2;
      3'h3:    acq_len = `ARF_ACQ_3;
      3'h4:    acq_len = `ARF_ACQ_4;
      3'h5:    acq_len = `ARF_ACQ_5;
      3'h6:    acq_len = `ARF_ACQ_6;
      default: acq_len = `ARF_ACQ_7;
    endcase
  endfunction

  function automatic logic [5:0] div_max(input arf_sel_t sel);
    case (sel)
      3'h0:    div_max = `ARF_DIV_2;
      3'h1:    div_max = `ARF_DIV_8;
      3'h2:    div_max = `ARF_DIV_32;
      3'h4:    div_max = `ARF_DIV_4;
      3'h5:    div_max = `ARF_DIV_16;
      3'h6:    div_max = `ARF_DIV_64;
      default: div_max = `ARF_DIV_RC;
    endcase
  endfunction

  arf_state_t state_r,  state_nxt;
  logic [5:0] div_r,    div_nxt;
  logic [4:0] acq_r,    acq_nxt;
  arf_code_t  trial_r,  trial_nxt;
  arf_code_t  mask_r,   mask_nxt;
  arf_code_t  result_r, result_nxt;
  arf_code_t  kept;
  logic       done_r,   done_nxt;
  logic       hold_r,   hold_nxt;
  logic       disch_r,  disch_nxt;
  logic       tick;

  assign tick = (div_r == div_max(sq.clk_sel));
  // Bits decided so far plus the verdict on the bit under trial
  assign kept = (trial_r & ~mask_r) | (sq.comp_in ? mask_r : `ARF_SAR_ZERO);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_nxt  = state_r;
    div_nxt    = (state_r == ARF_IDLE || tick) ? 6'h00 : div_r + 6'h01;
    acq_nxt    = acq_r;
    trial_nxt  = trial_r;
    mask_nxt   = mask_r;
    result_nxt = result_r;
    done_nxt   = 1'b0;
    hold_nxt   = hold_r;
    disch_nxt  = disch_r;
    case (state_r)
      ARF_IDLE: begin
        if (sq.run) begin
          // Code zero skips straight to conversion
          if (acq_len(sq.acq_code) == 5'h00) begin
            state_nxt = ARF_CONV;
            hold_nxt  = 1'b0;
            trial_nxt = `ARF_SAR_MSB;
            mask_nxt  = `ARF_SAR_MSB;
          end else begin
            state_nxt = ARF_ACQ;
            acq_nxt   = acq_len(sq.acq_code) - 5'h01;
          end
        end
      end
      ARF_ACQ: begin
        if (!sq.run) begin
          state_nxt = ARF_IDLE;
        end else if (tick) begin
          if (acq_r == 5'h00) begin
            state_nxt = ARF_CONV;
            hold_nxt  = 1'b0;
            trial_nxt = `ARF_SAR_MSB;
            mask_nxt  = `ARF_SAR_MSB;
          end else begin
            acq_nxt = acq_r - 5'h01;
          end
        end
      end
      ARF_CONV: begin
        if (!sq.run) begin
          // Aborted: no result, reconnect at once
          state_nxt = ARF_IDLE;
          hold_nxt  = 1'b1;
        end else if (tick) begin
          if (mask_r[0]) begin
            state_nxt  = ARF_DISCH;
            result_nxt = kept;
            done_nxt   = 1'b1;
            disch_nxt  = 1'b1;
          end else begin
            mask_nxt  = mask_r >> 1;
            trial_nxt = kept | (mask_r >> 1);
          end
        end
      end
      ARF_DISCH: begin
        // Discharge lasts one converter clock, cannot be cut short
        if (tick) begin
          state_nxt = ARF_IDLE;
          disch_nxt = 1'b0;
          hold_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ARF_IDLE;
        hold_nxt  = 1'b1;
        disch_nxt = 1'b0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= ARF_IDLE;
      div_r    <= 6'h00;
      acq_r    <= 5'h00;
      trial_r  <= `ARF_SAR_ZERO;
      mask_r   <= `ARF_SAR_ZERO;
      result_r <= `ARF_SAR_ZERO;
      done_r   <= 1'b0;
      hold_r   <= 1'b1;
      disch_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      div_r    <= div_nxt;
      acq_r    <= acq_nxt;
      trial_r  <= trial_nxt;
      mask_r   <= mask_nxt;
      result_r <= result_nxt;
      done_r   <= done_nxt;
      hold_r   <= hold_nxt;
      disch_r  <= disch_nxt;
    end
  end

  assign sq.busy      = (state_r != ARF_IDLE);
  assign sq.done      = done_r;
  assign sq.result    = result_r;
  assign sq.trial     = trial_r;
  assign sq.hold_on   = hold_r;
  assign sq.discharge = disch_r;

endmodule

// ---- rtl/arf_top.sv ----
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "arf_regs.svh"

// How it works
// - Left format: result 9..2 into high byte
// - Left format: result 1..0 into low 7..6
// - Right format: result 9..8 into high 1..0
// - Right format: result 7..0 into low byte
// - Result bytes writable, no reset value
// - Hold capacitor discharged after every completed conversion
// - Format bit one right, zero left
// - Go bit starts, hardware clears on completion
// - Acquisition code picks 0 to 20 periods
module arf_top (
  input  wire logic            CLOCK,
  input  wire logic            ARST_N,
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [11:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  input  wire logic [3:0]      PSTRB,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  input  wire logic            COMP_IN,
  output logic      [3:0]      CHANNEL_SEL,
  output logic      [1:0]      VREF_SEL,
  output logic                 CONV_ON,
  output logic                 HOLD_CONNECT,
  output logic                 HOLD_DISCHARGE,
  output arf_pkg::arf_code_t   DAC_CODE
);
  import arf_pkg::*;

  // Register map, byte addresses:
  //   0x000 channel, go, on
  //   0x004 reference select
  //   0x008 format, acquire, clock
  //   0x00C result high byte
  //   0x010 result low byte
  // Others: error, read zero,
  // write dropped.
  // Bits 31..8 always read zero.

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Left:  high = 9..2, low 7..6 = 1..0
  // Right: high 1..0 = 9..8, low = 7..0
  // Unused positions hold zero
  // Place a 10-bit result into the high and low bytes
  function automatic logic [15:0] fmt_result(input logic right, input arf_code_t res);
    if (right) begin
      fmt_result = {6'h00, res[9:8], res[7:0]};
    end else begin
      fmt_result = {res[9:2], res[1:0], 6'h00};
    end
  endfunction

  // Full compare: unaligned or
  // mirrored addresses are errors
  // Register select from a byte address, one-hot, zero when unmapped
  function automatic logic [4:0] decode(input logic [11:0] addr);
    if (addr == `ARF_OFF_CTRL_A) begin
      decode = 5'h01;
    end else if (addr == `ARF_OFF_CTRL_B) begin
      decode = 5'h02;
    end else if (addr == `ARF_OFF_CTRL_C) begin
      decode = 5'h04;
    end else if (addr == `ARF_OFF_RES_HIGH) begin
      decode = 5'h08;
    end else if (addr == `ARF_OFF_RES_LOW) begin
      decode = 5'h10;
    end else begin
      decode = 5'h00;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Link to the conversion sequencer
  arf_seq_if sq ();

  // Control fields and result bytes
  logic       on_r,    on_nxt;
  logic       go_r,    go_nxt;
  logic [3:0] chan_r,  chan_nxt;
  logic [1:0] vref_r,  vref_nxt;
  logic       fmt_r,   fmt_nxt;
  arf_sel_t   acq_r,   acq_nxt;
  arf_sel_t   clk_r,   clk_nxt;
  arf_byte_t  res_hi_r, res_hi_nxt;
  arf_byte_t  res_lo_r, res_lo_nxt;
  // Bus answer
  logic [31:0] rdata_r, rdata_nxt;
  logic       ready_r, ready_nxt;
  logic       err_r,   err_nxt;
  // Retimed analog controls
  logic       hold_r,  disch_r;
  arf_code_t  dac_r;
  // Decode, write strobe and formatted result
  logic [4:0] sel_setup;
  logic [4:0] sel_acc;
  logic       wr_en;
  logic [15:0] fmt_new;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // One transfer as the master sees it:
  //   setup:  read word sampled
  //   access: pready, write lands
  // No wait states, so pready is
  // never high two cycles running.
  // Upper lanes are ignored.

  // Write commits on the access edge that sees pready; lane 0 only
  assign sel_setup = decode(PADDR);
  assign sel_acc   = decode(PADDR);
  assign wr_en     = PSEL & PENABLE & ready_r & PWRITE & PSTRB[0];

  // Read data captured in the setup cycle so PRDATA comes from a flop;
  // the price is one cycle of staleness against hardware updates
  always_comb begin
    ready_nxt = PSEL & ~PENABLE;
    err_nxt   = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (PSEL & ~PENABLE) begin
      err_nxt = (sel_setup == 5'h00);
      if (sel_setup[0]) begin
        rdata_nxt = {24'h00_0000, 2'h0, chan_r, go_r, on_r};
      end else if (sel_setup[1]) begin
        rdata_nxt = {24'h00_0000, 2'h0, vref_r, 4'h0};
      end else if (sel_setup[2]) begin
        rdata_nxt = {24'h00_0000, fmt_r, 1'b0, acq_r, clk_r};
      end else if (sel_setup[3]) begin
        rdata_nxt = {24'h00_0000, res_hi_r};
      end else if (sel_setup[4]) begin
        rdata_nxt = {24'h00_0000, res_lo_r};
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Hardware touches only go; the
  // other fields change by bus write.
  // Dropping on or go mid-run aborts
  // and keeps the old result.
  // A set of go in the completion
  // cycle wins and starts a fresh
  // conversion after the discharge.

  // Hardware clears go on completion; a software set in the same cycle wins
  always_comb begin
    on_nxt   = on_r;
    go_nxt   = go_r;
    chan_nxt = chan_r;
    vref_nxt = vref_r;
    fmt_nxt  = fmt_r;
    acq_nxt  = acq_r;
    clk_nxt  = clk_r;
    if (sq.done) begin
      go_nxt = 1'b0;
    end
    if (wr_en && sel_acc[0]) begin
      on_nxt   = PWDATA[`ARF_A_ON_BIT];
      go_nxt   = PWDATA[`ARF_A_GO_BIT];
      chan_nxt = PWDATA[`ARF_A_CHAN_LSB +: 4];
    end else if (wr_en && sel_acc[1]) begin
      vref_nxt = PWDATA[`ARF_B_VREF_LSB +: 2];
    end else if (wr_en && sel_acc[2]) begin
      fmt_nxt  = PWDATA[`ARF_C_FMT_BIT];
      acq_nxt  = PWDATA[`ARF_C_ACQ_LSB +: 3];
      clk_nxt  = PWDATA[`ARF_C_CLK_LSB +: 3];
    end
  end

  // Control registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      on_r   <= `ARF_RST_ON;
      go_r   <= `ARF_RST_GO;
      chan_r <= `ARF_RST_CHAN;
      vref_r <= `ARF_RST_VREF;
      fmt_r  <= `ARF_RST_FMT;
      acq_r  <= `ARF_RST_ACQ;
      clk_r  <= `ARF_RST_CLK;
    end else begin
      on_r   <= on_nxt;
      go_r   <= go_nxt;
      chan_r <= chan_nxt;
      vref_r <= vref_nxt;
      fmt_r  <= fmt_nxt;
      acq_r  <= acq_nxt;
      clk_r  <= clk_nxt;
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************

  // Software may preload a byte,
  // but the next completion
  // overwrites both. The format bit
  // acts at load time: changing it
  // later leaves stored bits alone.

  // Completion load beats a software write landing in the same cycle
  assign fmt_new = fmt_result(fmt_r, sq.result);

  always_comb begin
    res_hi_nxt = res_hi_r;
    res_lo_nxt = res_lo_r;
    if (sq.done) begin
      res_hi_nxt = fmt_new[15:8];
      res_lo_nxt = fmt_new[7:0];
    end else if (wr_en && sel_acc[3]) begin
      res_hi_nxt = PWDATA[7:0];
    end else if (wr_en && sel_acc[4]) begin
      res_lo_nxt = PWDATA[7:0];
    end
  end

  // No reset: content is unknown until written or converted
  always_ff @(posedge CLOCK) begin
    res_hi_r <= res_hi_nxt;
    res_lo_r <= res_lo_nxt;
  end

  // ****************************************************************
  // Sequencer and analog-facing outputs
  // ****************************************************************

  // Acquisition counts converter
  // clock periods, so a slow clock
  // select stretches it in step.
  // Code zero gives no wait at all.

  // Channel changes are not policed; software owns the settling wait
  assign sq.run      = go_r & on_r;
  assign sq.acq_code = acq_r;
  assign sq.clk_sel  = clk_r;
  assign sq.comp_in  = COMP_IN;

  // Divides the system clock down
  // to the converter clock itself
  arf_seq u_seq (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .sq     (sq.seq)
  );

  // Pins lag the sequencer a cycle;
  // at /2 the comparator has one
  // cycle to answer a new code.
  // Retimed so every analog control leaves through a flop
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_r  <= 1'b1;
      disch_r <= 1'b0;
      dac_r   <= `ARF_SAR_ZERO;
    end else begin
      hold_r  <= sq.hold_on;
      disch_r <= sq.discharge;
      dac_r   <= sq.trial;
    end
  end

  // ****************************************************************
  // Top-level outputs
  // ****************************************************************

  // Bus, control and analog pins
  assign PRDATA         = rdata_r;
  assign PREADY         = ready_r;
  assign PSLVERR        = err_r;
  assign CHANNEL_SEL    = chan_r;
  assign VREF_SEL       = vref_r;
  assign CONV_ON        = on_r;
  assign HOLD_CONNECT   = hold_r;
  assign HOLD_DISCHARGE = disch_r;
  assign DAC_CODE       = dac_r;

endmodule

// ---- sim/arf_top_monitor.sv ----
`timescale 1ns/100ps
`include "arf_regs.svh"
// ****************************************************************
// Port-level checks of the result formatting block
// ****************************************************************
module arf_top_monitor
  import arf_pkg::*;
(
  input wire logic            CLOCK,
  input wire logic            ARST_N,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [11:0]     PADDR,
  input wire logic [31:0]     PWDATA,
  input wire logic [3:0]      PSTRB,
  input wire logic [31:0]     PRDATA,
  input wire logic            PREADY,
  input wire logic            PSLVERR,
  input wire logic            COMP_IN,
  input wire logic [3:0]      CHANNEL_SEL,
  input wire logic [1:0]      VREF_SEL,
  input wire logic            CONV_ON,
  input wire logic            HOLD_CONNECT,
  input wire logic            HOLD_DISCHARGE,
  input wire arf_code_t       DAC_CODE
);
  logic       wr_a;
  logic       wr_b;
  logic [3:0] wr_chan_r;
  logic       wr_on_r;
  logic [1:0] wr_vref_r;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // Completed writes to the two control words that drive pins
  assign wr_a = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && (PADDR == `ARF_OFF_CTRL_A);
  assign wr_b = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && (PADDR == `ARF_OFF_CTRL_B);

  // Last written field values, so pin checks do not depend on the data bus holding
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_chan_r <= 4'h0;
      wr_on_r   <= 1'b0;
      wr_vref_r <= 2'h0;
    end else begin
      if (wr_a) begin
        wr_chan_r <= PWDATA[5:2];
        wr_on_r   <= PWDATA[0];
      end
      if (wr_b) begin
        wr_vref_r <= PWDATA[5:4];
      end
    end
  end

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_wr_a;
    wr_a;
  endsequence
  sequence s_wr_b;
    wr_b;
  endsequence

  chk_ready_first: assert property (s_setup |=> PREADY) else $error("ready missing in access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data outside access");
  chk_rdata_byte: assert property (PRDATA[31:8] == 24'h0) else $error("upper read data not zero");
  chk_err_map: assert property (PREADY |-> PSLVERR == !(PADDR inside {`ARF_OFF_CTRL_A, `ARF_OFF_CTRL_B,
    `ARF_OFF_CTRL_C, `ARF_OFF_RES_HIGH, `ARF_OFF_RES_LOW})) else $error("error flag wrong for address");
  chk_chan_write: assert property (s_wr_a |=> ##[0:1] (CHANNEL_SEL == wr_chan_r && CONV_ON == wr_on_r))
    else $error("channel pins do not follow write");
  chk_vref_write: assert property (s_wr_b |=> ##[0:1] VREF_SEL == wr_vref_r)
    else $error("reference pins do not follow write");
  chk_disch_open: assert property (HOLD_DISCHARGE |-> !HOLD_CONNECT) else $error("discharge while connected");
  chk_disch_end: assert property ($fell(HOLD_DISCHARGE) |-> ##[0:1] HOLD_CONNECT)
    else $error("hold not reconnected after discharge");
endmodule

bind arf_top arf_top_monitor u_mon (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COMP_IN(COMP_IN),
  .CHANNEL_SEL(CHANNEL_SEL), .VREF_SEL(VREF_SEL), .CONV_ON(CONV_ON), .HOLD_CONNECT(HOLD_CONNECT),
  .HOLD_DISCHARGE(HOLD_DISCHARGE), .DAC_CODE(DAC_CODE)
);

// ---- sim/adc_result_formatting_bench.sv ----
`timescale 1ns/100ps
`include "arf_regs.svh"
module adc_result_formatting_bench;
  import arf_pkg::*;
  logic        CLOCK;
  logic        ARST_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [3:0]  PSTRB;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        COMP_IN;
  logic [3:0]  CHANNEL_SEL;
  logic [1:0]  VREF_SEL;
  logic        CONV_ON;
  logic        HOLD_CONNECT;
  logic        HOLD_DISCHARGE;
  arf_code_t   DAC_CODE;
  arf_code_t   target;
  logic        disch_seen;
  int          failures;
  int          compares;
  int          acq_n [8];
  int          acq_len [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  arf_code_t   tgt [8] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155, 10'h201, 10'h1FE, 10'h3C3, 10'h0A5};

  arf_top u_dut (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COMP_IN(COMP_IN),
    .CHANNEL_SEL(CHANNEL_SEL), .VREF_SEL(VREF_SEL), .CONV_ON(CONV_ON), .HOLD_CONNECT(HOLD_CONNECT),
    .HOLD_DISCHARGE(HOLD_DISCHARGE), .DAC_CODE(DAC_CODE)
  );

  // ****************************************************************
  // Clock, comparator stand-in and discharge watcher
  // ****************************************************************
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  // Comparator answers for an ideal input at the target level; one cycle late, well inside a period
  always @(posedge CLOCK) begin
    COMP_IN <= (target >= DAC_CODE);
    if (HOLD_DISCHARGE === 1'b1) disch_seen <= 1'b1;
  end

  // Cuts a hang short; the full run needs well under this
  initial begin
    #1200000;
    failures++;
    results();
  end

  // ****************************************************************
  // Bus cycle and compare helpers
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    apb(1'b0, `ARF_OFF_CTRL_A, 32'h0, q, e);
    chkw(q, 32'h0);
    apb(1'b0, `ARF_OFF_CTRL_C, 32'h0, q, e);
    chkw(q, 32'h0);
    chkb(HOLD_CONNECT, 1'b1);
    chkb(HOLD_DISCHARGE, 1'b0);
    $display("Test reset done");
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b1, `ARF_OFF_RES_HIGH, 32'hA5, q, e);
    apb(1'b1, `ARF_OFF_RES_LOW, 32'h5A, q, e);
    PSTRB <= 4'h0;
    apb(1'b1, `ARF_OFF_RES_HIGH, 32'hFF, q, e);
    PSTRB <= 4'hF;
    apb(1'b0, `ARF_OFF_RES_HIGH, 32'h0, q, e);
    chkw(q, 32'hA5);
    apb(1'b0, `ARF_OFF_RES_LOW, 32'h0, q, e);
    chkw(q, 32'h5A);
    apb(1'b1, `ARF_OFF_CTRL_B, 32'h30, q, e);
    apb(1'b0, `ARF_OFF_CTRL_B, 32'h0, q, e);
    chkw(q, 32'h30);
    chkw({30'h0, VREF_SEL}, 32'h3);
    apb(1'b0, 12'h014, 32'h0, q, e);
    chkw(q, 32'h0);
    chkb(e, 1'b1);
    $display("Test register access done");
  endtask

  // One conversion per acquisition code; odd codes right justified, even codes left
  task automatic t_conv(input int k);
    logic [31:0] q;
    logic        e;
    logic        j;
    logic [2:0]  c;
    int          n;
    j = k[0];
    c = k[2:0];
    target = tgt[k];
    disch_seen <= 1'b0;
    apb(1'b1, `ARF_OFF_CTRL_C, {24'h0, j, 1'b0, c, 3'h4}, q, e);
    // Channel and on first, go only after a full acquisition wait
    apb(1'b1, `ARF_OFF_CTRL_A, 32'h0D, q, e);
    repeat (90) @(posedge CLOCK);
    chkw({28'h0, CHANNEL_SEL}, 32'h3);
    chkb(CONV_ON, 1'b1);
    apb(1'b1, `ARF_OFF_CTRL_A, 32'h0F, q, e);
    n = 0;
    while (HOLD_CONNECT !== 1'b0 && n < 500) begin
      @(posedge CLOCK);
      n++;
    end
    acq_n[k] = n;
    apb(1'b0, `ARF_OFF_CTRL_A, 32'h0, q, e);
    chkb(q[1], 1'b1);
    n = 0;
    do begin
      apb(1'b0, `ARF_OFF_CTRL_A, 32'h0, q, e);
      n++;
    end while (q[1] !== 1'b0 && n < 100);
    chkw(q, 32'h0D);
    apb(1'b0, `ARF_OFF_RES_HIGH, 32'h0, q, e);
    chkw(q & (j ? 32'h03 : 32'hFF), j ? {30'h0, target[9:8]} : {24'h0, target[9:2]});
    apb(1'b0, `ARF_OFF_RES_LOW, 32'h0, q, e);
    chkw(q & (j ? 32'hFF : 32'hC0), j ? {24'h0, target[7:0]} : {24'h0, target[1:0], 6'h0});
    repeat (8) @(posedge CLOCK);
    chkb(disch_seen, 1'b1);
    chkb(HOLD_CONNECT, 1'b1);
    $display("Test conversion %0d done", k);
  endtask

  // Acquisition length shows as the delay before the hold switch opens
  task automatic t_acq;
    int k;
    for (k = 1; k < 8; k++) begin
      chkw(32'(acq_n[k] - acq_n[0]), 32'(acq_len[k] * 4));
    end
    $display("Test acquisition lengths done");
  endtask

  task automatic results;
    $display("Counts: compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    ARST_N     = 1'b0;
    PSEL       = 1'b0;
    PENABLE    = 1'b0;
    PWRITE     = 1'b0;
    PADDR      = 12'h000;
    PWDATA     = 32'h0;
    PSTRB      = 4'hF;
    COMP_IN    = 1'b0;
    target     = 10'h000;
    disch_seen = 1'b0;
    failures   = 0;
    compares   = 0;
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    t_reset();
    t_regs();
    for (int k = 0; k < 8; k++) begin
      t_conv(k);
    end
    t_acq();
    results();
  end
endmodule
